/* design/nic_ctrl.sv */
// Purpose: nested interrupt arbitration, priority flag bits and wake-up
// Assumes: core signals instruction ends and priority-changing instructions
// Notes:   request is registered; entry happens on instr_end with req high and no level-changing instruction
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`default_nettype none
// Notes on behaviour
// - non-maskable entry pushes context except on reset, sets level 3.
// - the trap instruction raises the non-maskable trap request.
// - reset outranks all and its routine runs at level 3.
// - maskable served only if enabled and above current level.
// - edge requests latch and clear on entry to their vector.
// - selected pins of one group are ORed onto their line.
// - peripheral request needs its flag and its enable bit.
// - peripheral clearing sequence discards its pending latch.
// - every source wakes from wait, only capable ones from halt.
// - after halt, a halt-capable request is served first.
// - flag bits 5 and 3 hold the current priority code.
// - maskable entry loads the vector's stored priority pair.
// - halt and wait load 10; return and pop restore stacked bits.
// - enable loads code 10, disable loads code 11.
// - trap and reset interrupt level 3 and set both bits.
// - four priority registers reset to FFh, top nibble of last is ones.
// - vector x owns pair x; pair 0 is the highest vector address.
// - writing level-0 code into a pair leaves that pair unchanged.
// - raised priority of an in-service pending vector re-enters it.
// - jump-if-masked when bits are 11, its complement otherwise.
// - fixed vector order, reset and trap at their own addresses.
// - per-source halt and active-halt wake capability.
// - highest software level wins, ties go to hardware order.
// - entry only at the end of the current instruction.
module nic_ctrl
  import nic_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rstn_in,
  // register port
  input  wire logic [2:0]           reg_addr_in,
  input  wire logic [7:0]           reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic      [7:0]           reg_rdata_out,
  // cpu core
  input  wire nic_pkg::nic_cpu_s    cpu_in,
  input  wire logic                 wait_mode_in,
  input  wire logic                 halt_mode_in,
  input  wire logic                 active_halt_in,
  output nic_pkg::nic_irq_s         irq_out,
  output logic                      take_out,
  output logic      [1:0]           prio_bits_out,
  output logic                      jump_if_masked_out,
  output logic                      jump_if_unmasked_out,
  output logic                      wake_out,
  // sources
  input  wire logic [15:0]          ext_pins_in,
  input  wire logic [15:0]          ext_sel_in,
  input  wire logic [5:0]           periph_flag_in,
  input  wire logic [5:0]           periph_en_in,
  input  wire logic [5:0]           periph_clr_in
);
  import nic_pkg::*;

  typedef struct packed {
    logic [3:0][7:0] prio_regs;
    logic [1:0]      prio;
    logic [15:0]     pin_meta;
    logic [15:0]     pin_sync;
    logic [3:0]      line_prev;
    logic [13:0]     pend;
    logic            trap_pend;
    logic            rst_pend;
    logic            halt_first;
    nic_irq_s        irq;
    logic            wake;
    logic [7:0]      rdata;
  } nic_state_s;

  nic_state_s st_ff;
  nic_state_s nxt_st;

  // code to level: 10->0, 01->1, 00->2, 11->3
  function automatic logic [1:0] nic_lvl(input logic [1:0] code);
    case (code)
      NIC_CODE_L0: nic_lvl = 2'h0;
      NIC_CODE_L1: nic_lvl = 2'h1;
      NIC_CODE_L2: nic_lvl = 2'h2;
      default:     nic_lvl = 2'h3;
    endcase
  endfunction : nic_lvl

  function automatic logic [1:0] nic_pair(input logic [3:0][7:0] regs,
                                          input logic [3:0]      v);
    logic [31:0] flat;
    flat     = regs;
    nic_pair = flat[{v, 1'b0} +: 2];
  endfunction : nic_pair

  logic [3:0]  line_now;
  logic [3:0]  line_rise;
  logic [5:0]  per_req;
  logic [13:0] elig;
  logic [13:0] any_pend;
  logic        found;
  logic [1:0]  best_lvl;
  logic [3:0]  best_num;
  logic        prio_instr;
  logic        take;

  always_comb
  begin
    for (int g = 0; g < NIC_NGRP; g++)
    begin
      // selects gate the pins only after both synchroniser stages
      line_now[g] = |(st_ff.pin_sync[g*NIC_GPINS +: NIC_GPINS] &
                      ext_sel_in[g*NIC_GPINS +: NIC_GPINS]);
    end
    line_rise = line_now & ~st_ff.line_prev;
    per_req   = periph_flag_in & periph_en_in;
    any_pend  = st_ff.pend;
    elig      = '0;
    for (int v = 0; v < NIC_NVEC; v++)
    begin
      elig[v] = st_ff.pend[v] &&
        (nic_lvl(nic_pair(st_ff.prio_regs, 4'(v))) > nic_lvl(st_ff.prio));
    end
    if (st_ff.halt_first)
    begin
      elig = elig & (active_halt_in ? NIC_AHALT_WAKE : NIC_HALT_WAKE);
    end
    found    = 1'b0;
    best_lvl = 2'h0;
    best_num = NIC_NUM_NONE;
    for (int v = 0; v < NIC_NVEC; v++)
    begin
      // ascending index is descending hardware priority
      if (elig[v] && (!found ||
          nic_lvl(nic_pair(st_ff.prio_regs, 4'(v))) > best_lvl))
      begin
        found    = 1'b1;
        best_lvl = nic_lvl(nic_pair(st_ff.prio_regs, 4'(v)));
        best_num = 4'(v);
      end
    end
    prio_instr = cpu_in.enable_all | cpu_in.disable_all | cpu_in.halt_instr |
                 cpu_in.wait_instr | cpu_in.ret | cpu_in.pop_flags;
    // an instruction that changes the level defers entry by one boundary
    take = cpu_in.instr_end && st_ff.irq.req && !prio_instr;
  end

  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.pin_meta  = ext_pins_in;
    nxt_st.pin_sync  = st_ff.pin_meta;
    nxt_st.line_prev = line_now;
    nxt_st.rdata     = 8'h00;

    // priority registers
    if (reg_wr_in && reg_addr_in <= NIC_OFS_PRIO3)
    begin
      for (int p = 0; p < 4; p++)
      begin
        if (reg_wdata_in[2*p +: 2] != NIC_CODE_L0)
        begin
          nxt_st.prio_regs[reg_addr_in[1:0]][2*p +: 2] =
            reg_wdata_in[2*p +: 2];
        end
      end
      if (reg_addr_in == NIC_OFS_PRIO3)
      begin
        nxt_st.prio_regs[3] = nxt_st.prio_regs[3] | NIC_PRIO3_RO;
      end
    end
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        NIC_OFS_PRIO0,
        NIC_OFS_PRIO1,
        NIC_OFS_PRIO2,
        NIC_OFS_PRIO3:  nxt_st.rdata = st_ff.prio_regs[reg_addr_in[1:0]];
        NIC_OFS_STATUS:
        begin
          nxt_st.rdata[NIC_FLAG_HIGH] = st_ff.prio[1];
          nxt_st.rdata[NIC_FLAG_LOW]  = st_ff.prio[0];
          nxt_st.rdata[NIC_STAT_REQ]  = st_ff.irq.req;
        end
        default:        nxt_st.rdata = 8'h00;
      endcase
    end

    // level changes by instruction
    if (cpu_in.enable_all || cpu_in.halt_instr || cpu_in.wait_instr)
    begin
      nxt_st.prio = NIC_CODE_L0;
    end
    else if (cpu_in.disable_all)
    begin
      nxt_st.prio = NIC_CODE_L3;
    end
    else if (cpu_in.ret || cpu_in.pop_flags)
    begin
      nxt_st.prio = cpu_in.stack_prio;
    end

    // entry: clear first so a new event in the same cycle wins
    if (take)
    begin
      if (st_ff.irq.nmi)
      begin
        nxt_st.prio = NIC_CODE_L3;
        if (st_ff.irq.push_ctx)
        begin
          nxt_st.trap_pend = 1'b0;
        end
        else
        begin
          nxt_st.rst_pend = 1'b0;
        end
      end
      else
      begin
        nxt_st.prio = nic_pair(st_ff.prio_regs, st_ff.irq.num);
        nxt_st.pend[st_ff.irq.num] = 1'b0;
        nxt_st.halt_first = 1'b0;
      end
    end
    for (int p = 0; p < NIC_NPER; p++)
    begin
      if (periph_clr_in[p])
      begin
        nxt_st.pend[NIC_PER_VEC[p]] = 1'b0;
      end
      if (per_req[p])
      begin
        nxt_st.pend[NIC_PER_VEC[p]] = 1'b1;
      end
    end
    for (int g = 0; g < NIC_NGRP; g++)
    begin
      if (line_rise[g])
      begin
        nxt_st.pend[NIC_EXT_BASE + 4'(g)] = 1'b1;
      end
    end
    if (cpu_in.trap)
    begin
      nxt_st.trap_pend = 1'b1;
    end
    if (halt_mode_in)
    begin
      nxt_st.halt_first = 1'b1;
    end

    // wake decision
    nxt_st.wake = 1'b0;
    if (halt_mode_in)
    begin
      nxt_st.wake = |(any_pend &
        (active_halt_in ? NIC_AHALT_WAKE : NIC_HALT_WAKE));
    end
    else if (wait_mode_in)
    begin
      nxt_st.wake = (|any_pend) | st_ff.trap_pend;
    end

    // registered request, dropped for one cycle after each entry
    nxt_st.irq = '0;
    nxt_st.irq.num = NIC_NUM_NONE;
    if (take)
    begin
      nxt_st.irq.req = 1'b0;
    end
    else if (st_ff.rst_pend)
    begin
      nxt_st.irq.req    = 1'b1;
      nxt_st.irq.vector = NIC_VEC_RESET;
      nxt_st.irq.nmi    = 1'b1;
    end
    else if (st_ff.trap_pend && !halt_mode_in && !st_ff.halt_first)
    begin
      nxt_st.irq.req      = 1'b1;
      nxt_st.irq.vector   = NIC_VEC_TRAP;
      nxt_st.irq.nmi      = 1'b1;
      nxt_st.irq.push_ctx = 1'b1;
    end
    else if (found && !halt_mode_in)
    begin
      nxt_st.irq.req      = 1'b1;
      nxt_st.irq.num      = best_num;
      nxt_st.irq.vector   = NIC_VEC_TOP - {11'h000, best_num, 1'b0};
      nxt_st.irq.push_ctx = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_ff            <= '0;
      st_ff.prio_regs  <= {4{NIC_PRIO_RST}};
      st_ff.prio       <= NIC_CODE_L3;
      st_ff.rst_pend   <= 1'b1;
      st_ff.irq.num    <= NIC_NUM_NONE;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_out        = st_ff.rdata;
  assign irq_out              = st_ff.irq;
  assign take_out             = take;
  assign prio_bits_out        = st_ff.prio;
  assign jump_if_masked_out   = (st_ff.prio == NIC_CODE_L3);
  assign jump_if_unmasked_out = (st_ff.prio != NIC_CODE_L3);
  assign wake_out             = st_ff.wake;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  property p_nmi_level;
    take && st_ff.irq.nmi |=> st_ff.prio == NIC_CODE_L3;
  endproperty
  a_nmi_level: assert property (p_nmi_level)
    else $error("nmi entry did not set level 3");

  property p_reset_first;
    st_ff.rst_pend |-> !st_ff.irq.req || !st_ff.irq.push_ctx;
  endproperty
  a_reset_first: assert property (p_reset_first)
    else $error("reset request pushed context or was outranked");

  property p_mask_level;
    st_ff.irq.req && !st_ff.irq.nmi |->
      nic_lvl(nic_pair($past(st_ff.prio_regs), st_ff.irq.num)) >
      $past(nic_lvl(st_ff.prio));
  endproperty
  a_mask_level: assert property (p_mask_level)
    else $error("maskable request not above current level");

  property p_entry_level;
    take && !st_ff.irq.nmi |=>
      st_ff.prio == nic_pair($past(st_ff.prio_regs), $past(st_ff.irq.num));
  endproperty
  a_entry_level: assert property (p_entry_level)
    else $error("entry did not load vector priority");

  property p_enable_code;
    cpu_in.enable_all && !cpu_in.ret && !cpu_in.pop_flags ##1 1'b1
      |-> st_ff.prio == NIC_CODE_L0;
  endproperty
  a_enable_code: assert property (p_enable_code)
    else $error("enable did not load code 10");

  property p_disable_code;
    cpu_in.disable_all && !cpu_in.enable_all && !cpu_in.halt_instr &&
    !cpu_in.wait_instr |=> st_ff.prio == NIC_CODE_L3;
  endproperty
  a_disable_code: assert property (p_disable_code)
    else $error("disable did not load code 11");

  property p_prio3_top;
    st_ff.prio_regs[3][7:4] == 4'hF;
  endproperty
  a_prio3_top: assert property (p_prio3_top)
    else $error("upper nibble of last priority register not ones");

  property p_l0_ignored;
    reg_wr_in && reg_addr_in == NIC_OFS_PRIO0 &&
    reg_wdata_in[1:0] == NIC_CODE_L0 |=>
      st_ff.prio_regs[0][1:0] == $past(st_ff.prio_regs[0][1:0]);
  endproperty
  a_l0_ignored: assert property (p_l0_ignored)
    else $error("level-0 code was stored");

  property p_periph_cause;
    $rose(st_ff.pend[NIC_PER_VEC[2]]) |-> $past(per_req[2]);
  endproperty
  a_periph_cause: assert property (p_periph_cause)
    else $error("peripheral pending without flag and enable");

  property p_halt_wake;
    halt_mode_in && !active_halt_in && st_ff.pend[8] &&
    !(|(st_ff.pend & NIC_HALT_WAKE)) |=> !wake_out;
  endproperty
  a_halt_wake: assert property (p_halt_wake)
    else $error("non-capable source woke from halt");

  property p_take_boundary;
    take |-> cpu_in.instr_end ##1 !st_ff.irq.req;
  endproperty
  a_take_boundary: assert property (p_take_boundary)
    else $error("entry outside a boundary or request held");

  c_reset_entry: cover property (take && st_ff.irq.vector == NIC_VEC_RESET);
  c_trap_entry:  cover property (take && st_ff.irq.vector == NIC_VEC_TRAP);
  c_ext_entry:   cover property (take && st_ff.irq.num == NIC_EXT_BASE);
  c_halt_wake:   cover property (halt_mode_in ##1 wake_out);
endmodule : nic_ctrl
`default_nettype wire

/* include/nic_pkg.sv */
// Purpose: shared constants and carriers of the nested interrupt controller
// Assumes: one cpu clock, registers reached over a plain strobe port
// Notes:   vector n of the maskable set sits at NIC_VEC_TOP - 2*n
`default_nettype none
package nic_pkg;
  localparam int unsigned NIC_NVEC   = 14;
  localparam int unsigned NIC_NGRP   = 4;
  localparam int unsigned NIC_GPINS  = 4;
  localparam int unsigned NIC_NPER   = 6;
  // register offsets of the plain register port
  localparam logic [2:0] NIC_OFS_PRIO0  = 3'h0;
  localparam logic [2:0] NIC_OFS_PRIO1  = 3'h1;
  localparam logic [2:0] NIC_OFS_PRIO2  = 3'h2;
  localparam logic [2:0] NIC_OFS_PRIO3  = 3'h3;
  localparam logic [2:0] NIC_OFS_STATUS = 3'h4;
  localparam logic [7:0] NIC_PRIO_RST   = 8'hFF;
  localparam logic [7:0] NIC_PRIO3_RO   = 8'hF0;
  // flag register layout of the current priority
  localparam int unsigned NIC_FLAG_HIGH = 5;
  localparam int unsigned NIC_FLAG_LOW  = 3;
  localparam int unsigned NIC_STAT_REQ  = 7;
  // priority codes
  localparam logic [1:0] NIC_CODE_L0 = 2'h2;
  localparam logic [1:0] NIC_CODE_L1 = 2'h1;
  localparam logic [1:0] NIC_CODE_L2 = 2'h0;
  localparam logic [1:0] NIC_CODE_L3 = 2'h3;
  // vector addresses
  localparam logic [15:0] NIC_VEC_RESET = 16'hFFFE;
  localparam logic [15:0] NIC_VEC_TRAP  = 16'hFFFC;
  localparam logic [15:0] NIC_VEC_TOP   = 16'hFFFA;
  localparam logic [3:0]  NIC_NUM_NONE  = 4'hF;
  localparam logic [3:0]  NIC_EXT_BASE  = 4'h2;
  // peripheral slot p feeds vector NIC_PER_VEC[p]
  localparam logic [5:0][3:0] NIC_PER_VEC =
    {4'hB, 4'hA, 4'h9, 4'h8, 4'h7, 4'h1};
  // halt and active-halt wake capability per vector, and the external vectors
  localparam logic [13:0] NIC_HALT_WAKE   = 14'h00BC;
  localparam logic [13:0] NIC_AHALT_WAKE  = 14'h00BE;
  localparam logic [13:0] NIC_EXT_VECS    = 14'h003C;

  typedef struct packed {
    logic       instr_end;
    logic       enable_all;
    logic       disable_all;
    logic       halt_instr;
    logic       wait_instr;
    logic       ret;
    logic       pop_flags;
    logic       trap;
    logic [1:0] stack_prio;
  } nic_cpu_s;

  typedef struct packed {
    logic        req;
    logic [15:0] vector;
    logic [3:0]  num;
    logic        push_ctx;
    logic        nmi;
  } nic_irq_s;
endpackage : nic_pkg
`default_nettype wire

/* tb/nic_cpu_model.sv */
// Purpose: behavioural cpu core facing the interrupt controller
// Assumes: an instruction ends every cycle, or every third one when slow
// Notes:   flags pushed on entry come back on return or pop
`default_nettype none
module nic_cpu_model (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  // bench commands
  input  wire logic              slow_in,
  input  wire logic [2:0]        op_in,
  // controller side
  input  wire logic              take_in,
  input  wire logic [1:0]        prio_in,
  input  wire nic_pkg::nic_irq_s irq_in,
  output var  nic_pkg::nic_cpu_s cpu_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import nic_pkg::*;
  logic [1:0] stk [$];
  logic [1:0] cnt_ff;
  logic [1:0] last_ff;

  always @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      cpu_out <= '0;
      cnt_ff  <= 2'h0;
      last_ff <= 2'h0;
    end
    else
    begin
      if (take_in && irq_in.push_ctx)
        stk.push_back(prio_in);
      cnt_ff <= (cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
      // a commanded instruction always ends in its own cycle
      cpu_out.instr_end   <= !slow_in || cnt_ff == 2'h2 || op_in != 3'h0;
      cpu_out.enable_all  <= op_in == 3'h1;
      cpu_out.disable_all <= op_in == 3'h2;
      cpu_out.halt_instr  <= op_in == 3'h3;
      cpu_out.wait_instr  <= op_in == 3'h4;
      cpu_out.ret         <= op_in == 3'h5;
      cpu_out.pop_flags   <= op_in == 3'h6;
      cpu_out.trap        <= op_in == 3'h7;
      if ((op_in == 3'h5 || op_in == 3'h6) && stk.size() != 0)
      begin
        last_ff            <= stk[$];
        cpu_out.stack_prio <= stk[$];
        void'(stk.pop_back());
      end
      else
        cpu_out.stack_prio <= ~last_ff;
    end
endmodule : nic_cpu_model
`default_nettype wire

/* tb/nested_interrupt_controller_tb_top.sv */
// Purpose: self-checking bench of the nested interrupt controller
// Assumes: registers over the plain strobe port, cpu from the core model
// Notes:   entries and reads are checked against queued expectations
`default_nettype none
module nested_interrupt_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import nic_pkg::*;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [2:0]  addr = '0;
  logic [7:0]  wdata = '0;
  logic        wr = 1'b0, rd = 1'b0, rd_q = 1'b0, slow = 1'b0;
  logic        wmode = 1'b0, hmode = 1'b0, ahalt = 1'b0;
  logic [2:0]  op = '0;
  logic [15:0] pins = '0, sel = '0;
  logic [5:0]  pflag = '0, pen = '0, pclr = '0;
  nic_cpu_s    cpu;
  nic_irq_s    irq;
  logic        take, jm, jnm, wake;
  logic [1:0]  prio;
  logic [7:0]  rdata;
  logic [7:0]  shadow [4];
  logic [15:0] exp_vec [$];
  logic [15:0] exp_rd [$];
  logic [15:0] mon_e;
  int          fails = 0, cmp_count = 0;

  always #50 clk_in = ~clk_in;

  nic_ctrl u_nic_ctrl (
    .clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .cpu_in(cpu), .wait_mode_in(wmode),
    .halt_mode_in(hmode), .active_halt_in(ahalt), .irq_out(irq),
    .take_out(take), .prio_bits_out(prio), .jump_if_masked_out(jm),
    .jump_if_unmasked_out(jnm), .wake_out(wake), .ext_pins_in(pins),
    .ext_sel_in(sel), .periph_flag_in(pflag), .periph_en_in(pen),
    .periph_clr_in(pclr));
  nic_cpu_model u_nic_cpu_model (
    .clk_in(clk_in), .rstn_in(rstn_in), .slow_in(slow), .op_in(op),
    .take_in(take), .prio_in(prio), .irq_in(irq), .cpu_out(cpu));

  task automatic check(input string what, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // pairs written with the level-0 code keep their old value
  function automatic logic [7:0] merge(input logic [7:0] o, w);
    for (int p = 0; p < 4; p++)
      if (w[2*p+:2] != NIC_CODE_L0)
        o[2*p+:2] = w[2*p+:2];
    return o;
  endfunction : merge

  function automatic logic [7:0] st(input logic [1:0] c);
    return {2'b00, c[1], 1'b0, c[0], 3'b000};
  endfunction : st

  task automatic wr_reg(input int r, input logic [7:0] d);
    if (r < 4)
      shadow[r] = merge(shadow[r], d) | (r == 3 ? NIC_PRIO3_RO : 8'h00);
    @(posedge clk_in);
    addr <= 3'(r);
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a, input logic [7:0] m, v);
    exp_rd.push_back({m, v});
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
  endtask : rd_reg

  task automatic do_op(input logic [2:0] o);
    @(posedge clk_in);
    op <= o;
    @(posedge clk_in);
    op <= 3'h0;
  endtask : do_op

  task automatic set_code(input logic [2:0] o, input logic [1:0] c);
    do_op(o);
    rd_reg(NIC_OFS_STATUS, 8'h28, st(c));
    check("jump masked", jm, c == NIC_CODE_L3);
    check("jump unmasked", jnm, c != NIC_CODE_L3);
  endtask : set_code

  task automatic wait_take(input int left);
    for (int i = 0; i < 60 && exp_vec.size() > left; i++)
      @(posedge clk_in);
    if (exp_vec.size() > left)
    begin
      check("entry wait", 16'h0, 16'h1);
      tally_and_finish();
    end
  endtask : wait_take

  // ends a peripheral routine: flag dropped, clear sequence, return
  task automatic serve(input int left, slot, input logic [5:0] fl);
    wait_take(left);
    pflag <= fl;
    pclr <= 6'(1 << slot);
    @(posedge clk_in);
    pclr <= 6'h00;
    do_op(3'h5);
  endtask : serve

  always @(posedge clk_in)
  begin
    rd_q <= rd;
    if (rd_q)
    begin
      mon_e = exp_rd.pop_front();
      check("read data", rdata & mon_e[15:8], mon_e[7:0]);
    end
    if (take)
    begin
      mon_e = (exp_vec.size() != 0) ? exp_vec.pop_front() : 16'h0;
      check("entry vector", irq.vector, mon_e);
    end
  end

  initial
  begin
    void'($urandom(32'h8B8B));
    exp_vec.push_back(NIC_VEC_RESET);
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    wait_take(0);
    rd_reg(NIC_OFS_STATUS, 8'h28, st(NIC_CODE_L3));
    for (int r = 0; r < 4; r++)
    begin
      shadow[r] = NIC_PRIO_RST;
      rd_reg(3'(r), 8'hFF, NIC_PRIO_RST);
    end
    rd_reg(3'h5, 8'hFF, 8'h00);
    for (int k = 0; k < 16; k++)
      wr_reg($urandom_range(4), 8'($urandom));
    for (int r = 0; r < 4; r++)
      rd_reg(3'(r), 8'hFF, shadow[r]);
    exp_vec.push_back(NIC_VEC_TRAP);
    set_code(3'h7, NIC_CODE_L3);
    wait_take(0);
    set_code(3'h5, NIC_CODE_L3);
    wr_reg(0, 8'h7F);
    wr_reg(1, 8'h7F);
    wr_reg(2, 8'hF4);
    set_code(3'h1, NIC_CODE_L0);
    set_code(3'h3, NIC_CODE_L0);
    set_code(3'h2, NIC_CODE_L3);
    set_code(3'h4, NIC_CODE_L0);
    set_code(3'h2, NIC_CODE_L3);
    // unselected pin first, then a selected one while masked
    sel <= 16'h0030;
    pins <= 16'h0040;
    repeat (4) @(posedge clk_in);
    pins <= 16'h0060;
    repeat (10) @(posedge clk_in);
    exp_vec.push_back(16'hFFF4);
    do_op(3'h1);
    wait_take(0);
    rd_reg(NIC_OFS_STATUS, 8'h28, st(NIC_CODE_L1));
    pins <= 16'h0000;
    set_code(3'h6, NIC_CODE_L0);
    repeat (10) @(posedge clk_in);
    slow <= 1'b1;
    pflag <= 6'h0E;
    repeat (8) @(posedge clk_in);
    set_code(3'h2, NIC_CODE_L3);
    pen <= 6'h0E;
    repeat (3) @(posedge clk_in);
    pflag <= 6'h0C;
    pclr <= 6'h02;
    @(posedge clk_in);
    pclr <= 6'h00;
    hmode <= 1'b1;
    repeat (4) @(posedge clk_in);
    check("halt wake", wake, 1'b0);
    ahalt <= 1'b1;
    pen <= 6'h0F;
    pflag <= 6'h0D;
    repeat (4) @(posedge clk_in);
    check("active halt wake", wake, 1'b1);
    ahalt <= 1'b0;
    repeat (2) @(posedge clk_in);
    check("plain halt wake", wake, 1'b0);
    pflag <= 6'h0E;
    pclr <= 6'h01;
    @(posedge clk_in);
    pclr <= 6'h00;
    repeat (4) @(posedge clk_in);
    check("capable halt wake", wake, 1'b1);
    hmode <= 1'b0;
    wmode <= 1'b1;
    repeat (4) @(posedge clk_in);
    check("wait wake", wake, 1'b1);
    wmode <= 1'b0;
    // halt-capable vector first, the higher level nests right after it
    exp_vec.push_back(16'hFFEC);
    exp_vec.push_back(16'hFFEA);
    exp_vec.push_back(16'hFFE8);
    exp_vec.push_back(16'hFFE8);
    do_op(3'h1);
    serve(2, 2, 6'h0A);
    serve(2, 1, 6'h08);
    wait_take(1);
    wr_reg(2, 8'hFC);
    serve(0, 3, 6'h00);
    do_op(3'h5);
    repeat (10) @(posedge clk_in);
    rd_reg(NIC_OFS_STATUS, 8'h28, st(NIC_CODE_L0));
    repeat (4) @(posedge clk_in);
    tally_and_finish();
  end
endmodule : nested_interrupt_controller_tb_top
`default_nettype wire
